// ### include/ads_params.svh
// Constants of the converter scan sequencer
`ifndef ADS_PARAMS_SVH
`define ADS_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------
`define ADS_OFF_CTRL    8'h00
`define ADS_OFF_CHSEL   8'h04
`define ADS_OFF_STAT    8'h08
`define ADS_OFF_RES0    8'h10
`define ADS_OFF_RES1    8'h14
`define ADS_OFF_RES2    8'h18
`define ADS_OFF_RES3    8'h1c

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define ADS_CTRL_RST    8'h00
`define ADS_CHSEL_RST   8'h00
`define ADS_RES_RST     8'h00
`define ADS_MODE_SCAN1  2'h0
`define ADS_MODE_SCANC  2'h1
`define ADS_MODE_DUAL   2'h2
`define ADS_SRC_TMR     2'h0
`define ADS_SRC_IMM     2'h1
`define ADS_SRC_EDGE    2'h2
`define ADS_SLOT_LAST   2'h3
`define ADS_RESP_OKAY   2'h0
`define ADS_RESP_SLVERR 2'h2
`define ADS_STAT_DONE   0

`endif

// ### include/ads_pkg.sv
// Types of the converter scan sequencer
package ads_pkg;

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'h1,
      ST_ARMED = 3'h2,
      ST_CONV  = 3'h4
   } ads_state_t;

   // ------------------------------------------------------------
   // Control register layout
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic       irq_en;
      logic       enable;
      logic       edge_fall;
      logic [1:0] start_src;
      logic       step;
      logic [1:0] mode;
   } ads_ctrl_t;

   // ------------------------------------------------------------
   // Channel select register layout
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [1:0] dual_sec;
      logic [1:0] dual_fst;
      logic [3:0] mask;
   } ads_chsel_t;

   // ------------------------------------------------------------
   // Request to the analog converter
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic       start;
      logic [1:0] ch;
   } ads_conv_req_t;

endpackage

// ### rtl/ads_scan_seq.sv
// Converter scan sequencer with AXI4-Lite register slave
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ads_params.svh"

module ads_scan_seq
(
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  i_tmr0_ovf,
   input  wire logic                  i_edge_trigger_pin,
   output ads_pkg::ads_conv_req_t     o_conv_req,
   input  wire logic                  i_conv_done,
   input  wire logic [7:0]            i_conv_data,
   output logic                       o_done_irq
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n;

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   ads_pkg::ads_ctrl_t  ctrl_r;
   ads_pkg::ads_chsel_t chsel_r;
   ads_pkg::ads_state_t st_r;
   logic [7:0]          res_r [4];
   logic [1:0]          pos_r;
   logic                in_pass_r;
   logic                flag_r;
   logic                imm_pend_r;
   logic                conv_start_r;
   logic [1:0]          conv_ch_r;
   logic                aw_hold_r;
   logic                w_hold_r;
   logic [7:0]          aw_addr_r;
   logic [31:0]         w_data_r;
   logic [3:0]          w_strb_r;
   logic                wr_do;
   logic                ctrl_wr;
   logic                flag_clr;
   logic                pin_s1_r;
   logic                pin_s2_r;
   logic                pin_s3_r;
   logic                edge_pls;
   logic                trig;
   logic                go;
   logic                acc;
   logic                dual;
   logic                cont;
   logic [1:0]          first_pos;
   logic [1:0]          cur_pos;
   logic [2:0]          nxt_sel;
   logic                pass_end;
   logic [1:0]          pos_nxt;
   logic                done_set;
   logic                can_run;
   ads_pkg::ads_ctrl_t  ctrl_wd;

   // ------------------------------------------------------------
   // Channel search helpers
   // ------------------------------------------------------------
   function automatic logic [1:0] first_sel(input logic [3:0] m);
      logic [1:0] r;
      r = 2'h0;
      for (int i = 3; i >= 0; i--)
         if (m[i])
            r = 2'(i);
      return r;
   endfunction

   function automatic logic [2:0] next_sel(input logic [3:0] m,
                                           input logic [1:0] c);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 3; i >= 0; i--)
         if (m[i] && (2'(i) > c))
            r = {1'b1, 2'(i)};
      return r;
   endfunction

   // ------------------------------------------------------------
   // Pin synchroniser and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
      end
      else
      begin
         pin_s1_r <= i_edge_trigger_pin;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
      end
   end

   // Polarity picks rising or falling
   assign edge_pls = ctrl_r.edge_fall ? (pin_s3_r & ~pin_s2_r)
                                      : (~pin_s3_r & pin_s2_r);

   // ------------------------------------------------------------
   // Start sources and sequence decode
   // ------------------------------------------------------------
   assign dual = (ctrl_r.mode == `ADS_MODE_DUAL);
   assign cont = dual || (ctrl_r.mode == `ADS_MODE_SCANC);
   always_comb
   begin
      case (ctrl_r.start_src)
         `ADS_SRC_TMR:  trig = i_tmr0_ovf;
         `ADS_SRC_IMM:  trig = imm_pend_r;
         `ADS_SRC_EDGE: trig = edge_pls;
         default:       trig = 1'b0;
      endcase
   end

   assign can_run   = dual || (chsel_r.mask != 4'h0);
   assign first_pos = dual ? 2'h0 : first_sel(chsel_r.mask);
   assign cur_pos   = in_pass_r ? pos_r : first_pos;
   // Triggers only count while armed
   assign go        = (st_r == ads_pkg::ST_ARMED) && trig && can_run;
   assign acc       = (st_r == ads_pkg::ST_CONV) && i_conv_done;
   assign nxt_sel   = next_sel(chsel_r.mask, pos_r);
   assign pass_end  = dual ? (pos_r == `ADS_SLOT_LAST) : !nxt_sel[2];
   assign pos_nxt   = dual ? 2'(pos_r + 2'h1) : nxt_sel[1:0];
   assign done_set  = acc && (pass_end || ctrl_r.step);

   // ------------------------------------------------------------
   // Sequencer state machine
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r      <= ads_pkg::ST_IDLE;
         pos_r     <= 2'h0;
         in_pass_r <= 1'b0;
      end
      else if (!ctrl_r.enable)
      begin
         st_r      <= ads_pkg::ST_IDLE;
         in_pass_r <= 1'b0;
      end
      else
      begin
         case (st_r)
            ads_pkg::ST_IDLE:
               st_r <= ads_pkg::ST_ARMED;
            ads_pkg::ST_ARMED:
               if (go)
               begin
                  st_r      <= ads_pkg::ST_CONV;
                  pos_r     <= cur_pos;
                  in_pass_r <= 1'b1;
               end
            ads_pkg::ST_CONV:
               if (acc)
               begin
                  if (pass_end)
                  begin
                     in_pass_r <= 1'b0;
                     pos_r     <= first_pos;
                     if (cont && !ctrl_r.step && can_run)
                        st_r <= ads_pkg::ST_CONV;
                     else
                        st_r <= ads_pkg::ST_ARMED;
                  end
                  else
                  begin
                     pos_r <= pos_nxt;
                     if (ctrl_r.step)
                        st_r <= ads_pkg::ST_ARMED;
                  end
               end
            default:
               st_r <= ads_pkg::ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Converter request
   // ------------------------------------------------------------
   logic restart;
   assign restart = acc && ctrl_r.enable && ((!pass_end && !ctrl_r.step)
                    || (pass_end && cont && !ctrl_r.step && can_run));

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conv_start_r <= 1'b0;
         conv_ch_r    <= 2'h0;
      end
      else
      begin
         conv_start_r <= (go && ctrl_r.enable) || restart;
         if (go || restart)
         begin
            if (dual)
               conv_ch_r <= (go ? cur_pos[0] : (pass_end ? 1'b0
                             : pos_nxt[0])) ? chsel_r.dual_sec
                                            : chsel_r.dual_fst;
            else
               conv_ch_r <= go ? cur_pos
                            : (pass_end ? first_pos : pos_nxt);
         end
      end
   end

   assign o_conv_req = '{start: conv_start_r, ch: conv_ch_r};

   // ------------------------------------------------------------
   // Result registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         for (int i = 0; i < 4; i++)
            res_r[i] <= `ADS_RES_RST;
      else if (acc)
         res_r[pos_r] <= i_conv_data;
   end

   // ------------------------------------------------------------
   // Done flag, set wins over clear
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         flag_r <= 1'b0;
      else if (done_set)
         flag_r <= 1'b1;
      else if (flag_clr)
         flag_r <= 1'b0;
   end

   assign o_done_irq = flag_r && ctrl_r.irq_en;

   // ------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_hold_r;
   assign s_axi_wready  = !w_hold_r;
   assign wr_do         = aw_hold_r && w_hold_r && !s_axi_bvalid;
   assign ctrl_wr       = wr_do && (aw_addr_r == `ADS_OFF_CTRL)
                          && w_strb_r[0];
   assign flag_clr      = wr_do && (aw_addr_r == `ADS_OFF_STAT)
                          && w_strb_r[0] && w_data_r[`ADS_STAT_DONE];

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_hold_r    <= 1'b0;
         w_hold_r     <= 1'b0;
         aw_addr_r    <= 8'h00;
         w_data_r     <= 32'h0000_0000;
         w_strb_r     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ADS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_do)
         begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_r)
               `ADS_OFF_CTRL,
               `ADS_OFF_CHSEL,
               `ADS_OFF_STAT: s_axi_bresp <= `ADS_RESP_OKAY;
               default:       s_axi_bresp <= `ADS_RESP_SLVERR;
            endcase
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r  <= `ADS_CTRL_RST;
         chsel_r <= `ADS_CHSEL_RST;
      end
      else if (wr_do && w_strb_r[0])
      begin
         if (aw_addr_r == `ADS_OFF_CTRL)
            ctrl_r <= w_data_r[7:0];
         if (aw_addr_r == `ADS_OFF_CHSEL)
            chsel_r <= w_data_r[7:0];
      end
   end

   // Immediate start waits for the armed state
   assign ctrl_wd = w_data_r[7:0];

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         imm_pend_r <= 1'b0;
      else if (ctrl_wr)
         imm_pend_r <= (ctrl_wd.start_src == `ADS_SRC_IMM)
                       && ctrl_wd.enable;
      else if (go || !ctrl_r.enable)
         imm_pend_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `ADS_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `ADS_RESP_OKAY;
         case (s_axi_araddr)
            `ADS_OFF_CTRL:  s_axi_rdata <= {24'h0, ctrl_r};
            `ADS_OFF_CHSEL: s_axi_rdata <= {24'h0, chsel_r};
            `ADS_OFF_STAT:  s_axi_rdata <= {24'h0, 1'b0, pos_r,
                                            in_pass_r, st_r, flag_r};
            `ADS_OFF_RES0:  s_axi_rdata <= {24'h0, res_r[0]};
            `ADS_OFF_RES1:  s_axi_rdata <= {24'h0, res_r[1]};
            `ADS_OFF_RES2:  s_axi_rdata <= {24'h0, res_r[2]};
            `ADS_OFF_RES3:  s_axi_rdata <= {24'h0, res_r[3]};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `ADS_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   sequence s_conv_ends;
      (st_r == ads_pkg::ST_CONV) && i_conv_done;
   endsequence

   sequence s_busy;
      (st_r == ads_pkg::ST_CONV) && !i_conv_done;
   endsequence

   a_timer_starts: assert property (
      (st_r == ads_pkg::ST_ARMED) && ctrl_r.enable && can_run
      && (ctrl_r.start_src == `ADS_SRC_TMR) && i_tmr0_ovf
      |=> o_conv_req.start && (st_r == ads_pkg::ST_CONV))
      else $error("timer overflow did not start");

   a_busy_no_start: assert property (
      s_busy ##0 i_tmr0_ovf |=> !o_conv_req.start)
      else $error("timer retrigger during conversion");

   a_edge_ignored: assert property (
      s_busy ##0 edge_pls |=> !o_conv_req.start)
      else $error("edge retrigger during conversion");

   a_edge_single: assert property (
      edge_pls |=> !edge_pls)
      else $error("edge pulse longer than one cycle");

   a_imm_start: assert property (
      (st_r == ads_pkg::ST_ARMED) && imm_pend_r && ctrl_r.enable
      && can_run && (ctrl_r.start_src == `ADS_SRC_IMM)
      |=> o_conv_req.start ##1 !imm_pend_r)
      else $error("immediate start missed");

   a_result_store: assert property (
      s_conv_ends |=> res_r[$past(pos_r)] == $past(i_conv_data))
      else $error("result not stored");

   a_irq_pass_end: assert property (
      s_conv_ends ##0 !pass_end && !ctrl_r.step && !flag_r
      && !flag_clr |=> !flag_r)
      else $error("flag set before pass end");

   a_dual_flag: assert property (
      s_conv_ends ##0 dual && (pos_r == `ADS_SLOT_LAST) |=> flag_r)
      else $error("dual group flag missing");

   a_step_halt: assert property (
      s_conv_ends ##0 ctrl_r.step && ctrl_r.enable
      |=> flag_r && (st_r == ads_pkg::ST_ARMED) && !o_conv_req.start)
      else $error("single step did not halt");

   a_cont_restart: assert property (
      s_conv_ends ##0 pass_end && cont && !ctrl_r.step
      && ctrl_r.enable && can_run
      |=> o_conv_req.start && (pos_r == $past(first_pos)))
      else $error("continuous pass did not restart");

   a_stop_idle: assert property (
      !ctrl_r.enable |=> (st_r == ads_pkg::ST_IDLE) ##1 !o_conv_req.start)
      else $error("sequencer kept running when stopped");

endmodule

// ### verification/ads_conv_model.sv
// Behavioural model of the analog converter
`timescale 1ns/10ps

module ads_conv_model
(
   input  wire logic                   i_clk,
   input  wire logic                   i_nrst,
   input  wire ads_pkg::ads_conv_req_t i_req,
   input  wire logic [7:0]             i_lat,
   input  wire logic [7:0]             i_base,
   output logic                        o_done,
   output logic [7:0]                  o_data
);
   logic [7:0] cnt;
   logic [1:0] ch;
   logic       busy;

   // ----------------------------------------
   // One result per start, i_lat+1 cycles after it
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         busy   <= 1'b0;
         cnt    <= 8'h00;
         ch     <= 2'h0;
         o_done <= 1'b0;
         o_data <= 8'h00;
      end
      else
      begin
         o_done <= 1'b0;
         o_data <= ~o_data;
         if (i_req.start)
         begin
            busy <= 1'b1;
            cnt  <= i_lat;
            ch   <= i_req.ch;
         end
         else if (busy && cnt == 8'h00)
         begin
            busy   <= 1'b0;
            o_done <= 1'b1;
            o_data <= i_base ^ {4{ch}};
         end
         else if (busy)
            cnt <= cnt - 8'h01;
      end
   end
endmodule

// ### verification/adc_scan_sequencer_tb_top.sv
// Self-checking bench of the converter scan sequencer
`timescale 1ns/10ps
`include "ads_params.svh"

module adc_scan_sequencer_tb_top;
   logic                   i_clk;
   logic                   i_nrst;
   logic                   awv, awr, wv, wr_r, bv, bre, arv, arr, rv, rre;
   logic                   tmr, pin, cdone, irq;
   logic [7:0]             awa, ara, cdat, lat, base;
   logic [31:0]            wd, rdat, rd;
   logic [1:0]             br, rr, rsp;
   ads_pkg::ads_conv_req_t req;
   int                     mismatches, comparisons, starts, seed;

   ads_scan_seq dut (.i_clk(i_clk), .i_nrst(i_nrst),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rre), .i_tmr0_ovf(tmr),
      .i_edge_trigger_pin(pin), .o_conv_req(req), .i_conv_done(cdone),
      .i_conv_data(cdat), .o_done_irq(irq));

   ads_conv_model conv (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req),
      .i_lat(lat), .i_base(base), .o_done(cdone), .o_data(cdat));

   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   always @(posedge i_clk)
      if (req.start === 1'b1)
         starts++;

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task automatic tmo;
      mismatches++;
      $display("Error at %0t: wait ran out", $time);
      wrap_up();
   endtask

   // ----------------------------------------
   // AXI4-Lite master
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      bre <= 1'b1;
      for (n = 0; !(bre && bv); n++)
      begin
         @(posedge i_clk);
         if (n > 99)
            tmo();
         if (awv && awr)
            awv <= 1'b0;
         if (wv && wr_r)
            wv <= 1'b0;
      end
      rsp = br;
      bre <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic rdr(input logic [7:0] a);
      int n;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      for (n = 0; !(rre && rv); n++)
      begin
         @(posedge i_clk);
         if (n > 99)
            tmo();
         if (arv && arr)
            arv <= 1'b0;
      end
      rd  = rdat;
      rsp = rr;
      rre <= 1'b0;
      @(posedge i_clk);
   endtask

   // ----------------------------------------
   // Start events and one scenario
   // ----------------------------------------
   task automatic trig(input logic [1:0] s);
      if (s == `ADS_SRC_TMR)
         repeat (2)
         begin
            tmr <= 1'b1;
            @(posedge i_clk);
            tmr <= 1'b0;
            repeat (4) @(posedge i_clk);
         end
      if (s == `ADS_SRC_EDGE)
         repeat (4)
         begin
            pin <= ~pin;
            repeat (3) @(posedge i_clk);
         end
   endtask

   function automatic logic [7:0] ex(input logic [1:0] c);
      return base ^ {4{c}};
   endfunction

   task automatic run(input logic [1:0] m, input logic [1:0] s,
                      input logic st, input logic ef, input logic [7:0] cs);
      int n, e;
      logic f;
      ads_pkg::ads_ctrl_t c;
      c = '{1'b1, 1'b1, ef, s, st, m};
      lat  <= 8'(15 + ($random(seed) & 15));
      base <= 8'($random(seed));
      wr(`ADS_OFF_CHSEL, {24'h0, cs});
      starts = 0;
      wr(`ADS_OFF_CTRL, {24'h0, c});
      trig(s);
      for (n = 0; irq !== 1'b1; n++)
      begin
         @(posedge i_clk);
         if (n > 3000)
            tmo();
      end
      e = st ? 1 : (m == `ADS_MODE_DUAL) ? 4 : $countones(cs[3:0]);
      if ((m == `ADS_MODE_SCANC || m == `ADS_MODE_DUAL) && !st)
         chk(32'(starts >= e && starts <= e + 1), 32'h1);
      else
         chk(32'(starts), 32'(e));
      wr(`ADS_OFF_STAT, 32'h1);
      @(posedge i_clk);
      chk({31'h0, irq}, 32'h0);
      wr(`ADS_OFF_CTRL, 32'h0);
      e = starts;
      repeat (60) @(posedge i_clk);
      chk(32'(starts), 32'(e));
      f = 1'b0;
      for (n = 0; n < 4; n++)
      begin
         rdr(`ADS_OFF_RES0 + 8'(4 * n));
         if (m == `ADS_MODE_DUAL)
            chk(rd, {24'h0, ex(n[0] ? cs[7:6] : cs[5:4])});
         else if (cs[n] && !(st && f))
            chk(rd, {24'h0, ex(2'(n))});
         f = f | cs[n];
      end
      $display("Scenario mode %0d src %0d step %0d done", m, s, st);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   logic [1:0] tm [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
   logic [1:0] ts [7] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0};
   logic [6:0] tst = 7'b1100100;

   initial
   begin
      logic [7:0] cs;
      seed = 32'h09c6;
      {i_nrst, awv, wv, bre, arv, rre, tmr, pin} = 8'h00;
      {awa, ara, lat, base, wd} = '0;
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (4) @(posedge i_clk);
      rdr(`ADS_OFF_CTRL);
      chk(rd, {24'h0, `ADS_CTRL_RST});
      rdr(`ADS_OFF_CHSEL);
      chk(rd, {24'h0, `ADS_CHSEL_RST});
      rdr(`ADS_OFF_RES2);
      chk(rd, {24'h0, `ADS_RES_RST});
      rdr(8'h0c);
      chk(rd, 32'h0);
      chk({30'h0, rsp}, {30'h0, `ADS_RESP_SLVERR});
      wr(8'h20, 32'h5);
      chk({30'h0, rsp}, {30'h0, `ADS_RESP_SLVERR});
      $display("Register reset and map checks done");
      for (int k = 0; k < 7; k++)
      begin
         cs = 8'($random(seed));
         if (cs[3:0] == 4'h0)
            cs[0] = 1'b1;
         if (k == 1)
            cs[3:0] = 4'h1 << cs[5:4];
         run(tm[k], ts[k], tst[k], k == 4, cs);
      end
      wrap_up();
   end
endmodule
